// *** design/core_register_reset_init.sv ***
// Core register set with reset and wake-up initialization, APB slave
// Summary of operation
// - Interrupt wake with global enable pushes current PC to stack top.
// - Same wake advances the return stack pointer by one.
// - Same wake loads PC with 0008h (high) or 0018h (low).
// - Watchdog or interrupt wake sets a flag naming its cause.
// - Port A bit 6 works only in external-clock-IO or RC-IO mode.
// - In other oscillator modes port A bit 6 is off, reads zero.
// - Variants without port A bit 6 always read it as zero.
// - Unimplemented bits of core registers always read zero.
`timescale 1ns/10ps
`include "core_regs_map.svh"
module core_register_reset_init (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Reset and wake events
  input  wire logic        por_i,
  input  wire logic        reset_event_i,
  input  wire logic        wake_int_i,
  input  wire logic        wake_int_high_i,
  input  wire logic        wake_wdt_i,
  // Configuration
  input  wire logic [2:0]  osc_mode_i,
  input  wire logic        has_pa_bit6_i,
  // Port A and PC
  input  wire logic [7:0]  port_a_pins_i,
  output logic      [7:0]  port_a_output_latch_o,
  output logic      [7:0]  port_a_direction_o,
  output logic      [20:0] pc_o
);
  wake_if w ();

  logic [20:0] pc_reg, pc_next;
  logic [7:0]  tos_u_reg, tos_u_next, tos_h_reg, tos_h_next;
  logic [7:0]  tos_l_reg, tos_l_next, stk_reg, stk_next;
  logic [7:0]  latu_reg, latu_next, lath_reg, lath_next;
  logic [7:0]  tblu_reg, tblu_next, tblh_reg, tblh_next;
  logic [7:0]  tbll_reg, tbll_next, table_read_latch_reg, table_read_latch_next;
  logic [7:0]  prodh_reg, prodh_next, prodl_reg, prodl_next;
  logic [7:0]  ic0_reg, ic0_next, ic2_reg, ic2_next, ic3_reg, ic3_next;
  logic [7:0]  pal_reg, pal_next, pad_reg, pad_next;
  logic [7:0]  fsrh_reg, fsrh_next, fsrl_reg, fsrl_next;
  logic [7:0]  pir_reg, pir_next;
  logic [7:0]  pins_s1_reg, pins_s2_reg;
  logic [31:0] prdata_next;
  logic        pready_next, pslverr_next;
  logic        wr_en, ra6_en;
  logic [7:0]  pa_mask, rd_byte;

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `OFF_PERIPH_FLAGS);
  endfunction : mapped

  core_wake_ctrl u_wake (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .por_i           (por_i),
    .reset_event_i   (reset_event_i),
    .wake_int_i      (wake_int_i),
    .wake_int_high_i (wake_int_high_i),
    .wake_wdt_i      (wake_wdt_i),
    .gie_any_i       (ic0_reg[`GIE_HIGH_BIT] | ic0_reg[`GIE_LOW_BIT]),
    .w               (w)
  );

  assign ra6_en = has_pa_bit6_i && (osc_mode_i == `OSC_EXT_CLK_IO ||
                  osc_mode_i == `OSC_RC_IO);
  assign pa_mask = ra6_en ? 8'hFF : 8'hBF;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i &&
                 mapped(paddr_i);

  always_comb begin
    unique case (paddr_i)
      `OFF_TOS_UPPER:    rd_byte = tos_u_reg & `MASK_TOS_UPPER;
      `OFF_TOS_HIGH:     rd_byte = tos_h_reg;
      `OFF_TOS_LOW:      rd_byte = tos_l_reg;
      `OFF_STACK_PTR:    rd_byte = stk_reg & `MASK_STACK_PTR;
      `OFF_PC_LOW:       rd_byte = pc_reg[7:0];
      `OFF_PC_UP_LATCH:  rd_byte = latu_reg & `MASK_PC_UPPER;
      `OFF_PC_HI_LATCH:  rd_byte = lath_reg;
      `OFF_TBL_UPPER:    rd_byte = tblu_reg & `MASK_TBL_UPPER;
      `OFF_TBL_HIGH:     rd_byte = tblh_reg;
      `OFF_TBL_LOW:      rd_byte = tbll_reg;
      `OFF_TBL_LATCH:    rd_byte = table_read_latch_reg;
      `OFF_PROD_HIGH:    rd_byte = prodh_reg;
      `OFF_PROD_LOW:     rd_byte = prodl_reg;
      `OFF_INTCTL0:      rd_byte = ic0_reg;
      `OFF_INTCTL2:      rd_byte = ic2_reg & `MASK_INTCTL2;
      `OFF_INTCTL3:      rd_byte = ic3_reg & `MASK_INTCTL3;
      `OFF_PA_LATCH:     rd_byte = pal_reg & pa_mask;
      `OFF_PA_DIR:       rd_byte = pad_reg & pa_mask;
      `OFF_PA_PINS:      rd_byte = pins_s2_reg & pa_mask;
      `OFF_FSR0_HIGH:    rd_byte = fsrh_reg & `MASK_FSR_HIGH;
      `OFF_FSR0_LOW:     rd_byte = fsrl_reg;
      `OFF_PERIPH_FLAGS: rd_byte = pir_reg;
      default:           rd_byte = 8'h00;
    endcase
  end

  // Bus answer, one cycle after setup
  always_comb begin
    prdata_next  = prdata_o;
    pready_next  = psel_i && !penable_i;
    pslverr_next = psel_i && !penable_i && !mapped(paddr_i);
    if (psel_i && !penable_i && !pwrite_i) begin
      prdata_next = {24'h000000, rd_byte};
    end
  end

  always_comb begin
    pc_next = pc_reg;     tos_u_next = tos_u_reg; tos_h_next = tos_h_reg;
    tos_l_next = tos_l_reg; stk_next = stk_reg;   latu_next = latu_reg;
    lath_next = lath_reg; tblu_next = tblu_reg;   tblh_next = tblh_reg;
    tbll_next = tbll_reg; table_read_latch_next = table_read_latch_reg;
    prodh_next = prodh_reg; prodl_next = prodl_reg;
    ic0_next = ic0_reg;   ic2_next = ic2_reg;     ic3_next = ic3_reg;
    pal_next = pal_reg;   pad_next = pad_reg;     fsrh_next = fsrh_reg;
    fsrl_next = fsrl_reg; pir_next = pir_reg;
    if (wr_en) begin
      unique case (paddr_i)
        `OFF_TOS_UPPER:    tos_u_next = pwdata_i[7:0] & `MASK_TOS_UPPER;
        `OFF_TOS_HIGH:     tos_h_next = pwdata_i[7:0];
        `OFF_TOS_LOW:      tos_l_next = pwdata_i[7:0];
        `OFF_STACK_PTR:    stk_next = pwdata_i[7:0] & `MASK_STACK_PTR;
        `OFF_PC_LOW:       pc_next = {latu_reg[4:0], lath_reg,
                                      pwdata_i[7:0]};
        `OFF_PC_UP_LATCH:  latu_next = pwdata_i[7:0] & `MASK_PC_UPPER;
        `OFF_PC_HI_LATCH:  lath_next = pwdata_i[7:0];
        `OFF_TBL_UPPER:    tblu_next = pwdata_i[7:0] & `MASK_TBL_UPPER;
        `OFF_TBL_HIGH:     tblh_next = pwdata_i[7:0];
        `OFF_TBL_LOW:      tbll_next = pwdata_i[7:0];
        `OFF_TBL_LATCH:    table_read_latch_next = pwdata_i[7:0];
        `OFF_PROD_HIGH:    prodh_next = pwdata_i[7:0];
        `OFF_PROD_LOW:     prodl_next = pwdata_i[7:0];
        `OFF_INTCTL0:      ic0_next = pwdata_i[7:0];
        `OFF_INTCTL2:      ic2_next = pwdata_i[7:0] & `MASK_INTCTL2;
        `OFF_INTCTL3:      ic3_next = pwdata_i[7:0] & `MASK_INTCTL3;
        `OFF_PA_LATCH:     pal_next = pwdata_i[7:0];
        `OFF_PA_DIR:       pad_next = pwdata_i[7:0];
        `OFF_FSR0_HIGH:    fsrh_next = pwdata_i[7:0] & `MASK_FSR_HIGH;
        `OFF_FSR0_LOW:     fsrl_next = pwdata_i[7:0];
        `OFF_PERIPH_FLAGS: pir_next = pwdata_i[7:0];
        default:           pc_next = pc_reg;
      endcase
    end
    unique case (w.act)
      core_regs_pkg::ACT_NONE: begin
        pc_next = pc_next;
      end
      core_regs_pkg::ACT_RESET: begin
        pc_next = 21'h000000;
        latu_next = 8'h00;
        lath_next = 8'h00;
        tblu_next = 8'h00;
        tblh_next = 8'h00;
        tbll_next = 8'h00;
        table_read_latch_next = 8'h00;
        tos_u_next = 8'h00;
        tos_h_next = 8'h00;
        tos_l_next = 8'h00;
        stk_next = w.por ? 8'h00 : (stk_reg & 8'hC0);
        ic0_next = w.por ? 8'h00 : (ic0_reg & 8'h01);
        ic2_next = `RST_INTCTL2;
        ic3_next = `RST_INTCTL3;
      end
      core_regs_pkg::ACT_VECTOR: begin
        {tos_u_next[4:0], tos_h_next, tos_l_next} = pc_reg;
        tos_u_next[7:5] = 3'h0;
        stk_next[4:0] = stk_reg[4:0] + 5'h01;
        if (stk_reg[4:0] == 5'h1F) begin
          stk_next[`STK_FULL_BIT] = 1'b1;
        end
        pc_next = w.vec;
      end
      core_regs_pkg::ACT_RESUME: begin
        pc_next = pc_reg + `PC_STEP;
      end
    endcase
    if (w.int_wake) begin
      ic0_next[`INT_WAKE_BIT] = 1'b1;
    end
    if (w.wdt_wake) begin
      pir_next[`WDT_WAKE_BIT] = 1'b1;
    end
    pal_next[`PA_BIT6] = pal_next[`PA_BIT6] & ra6_en;
    pad_next[`PA_BIT6] = pad_next[`PA_BIT6] & ra6_en;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_reg <= 21'h000000; tos_u_reg <= 8'h00; tos_h_reg <= 8'h00;
      tos_l_reg <= 8'h00;   stk_reg <= 8'h00;   latu_reg <= 8'h00;
      lath_reg <= 8'h00;    tblu_reg <= 8'h00;  tblh_reg <= 8'h00;
      tbll_reg <= 8'h00;    table_read_latch_reg <= 8'h00;
      prodh_reg <= 8'h00;   prodl_reg <= 8'h00; ic0_reg <= 8'h00;
      ic2_reg <= `RST_INTCTL2; ic3_reg <= `RST_INTCTL3;
      pal_reg <= 8'h00;     pad_reg <= `RST_PA_DIR & 8'hBF;
      fsrh_reg <= 8'h00;    fsrl_reg <= 8'h00;  pir_reg <= 8'h00;
      pins_s1_reg <= 8'h00; pins_s2_reg <= 8'h00;
      prdata_o <= 32'h00000000; pready_o <= 1'b0; pslverr_o <= 1'b0;
    end else begin
      pc_reg <= pc_next;    tos_u_reg <= tos_u_next; tos_h_reg <= tos_h_next;
      tos_l_reg <= tos_l_next; stk_reg <= stk_next;  latu_reg <= latu_next;
      lath_reg <= lath_next; tblu_reg <= tblu_next;  tblh_reg <= tblh_next;
      tbll_reg <= tbll_next; table_read_latch_reg <= table_read_latch_next;
      prodh_reg <= prodh_next; prodl_reg <= prodl_next; ic0_reg <= ic0_next;
      ic2_reg <= ic2_next;  ic3_reg <= ic3_next;
      pal_reg <= pal_next;  pad_reg <= pad_next;
      fsrh_reg <= fsrh_next; fsrl_reg <= fsrl_next; pir_reg <= pir_next;
      pins_s1_reg <= port_a_pins_i;
      pins_s2_reg <= pins_s1_reg;
      prdata_o <= prdata_next; pready_o <= pready_next;
      pslverr_o <= pslverr_next;
    end
  end

  assign port_a_output_latch_o = pal_reg;
  assign port_a_direction_o    = pad_reg;
  assign pc_o                  = pc_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  tos_push_a: assert property (
    w.act == core_regs_pkg::ACT_VECTOR |=>
    {tos_u_reg[4:0], tos_h_reg, tos_l_reg} == $past(pc_reg))
    else $error("stack top not loaded with PC");
  stack_advance_a: assert property (
    w.act == core_regs_pkg::ACT_VECTOR |=>
    stk_reg[4:0] == $past(stk_reg[4:0]) + 5'h01)
    else $error("stack pointer not advanced");
  vector_load_a: assert property (
    wake_int_i && !por_i && !reset_event_i &&
    (ic0_reg[`GIE_HIGH_BIT] || ic0_reg[`GIE_LOW_BIT]) |=> ##1
    pc_o == ($past(wake_int_high_i, 2) ? `VEC_HIGH : `VEC_LOW))
    else $error("PC not loaded with vector");
  wake_flag_a: assert property (
    (wake_int_i || wake_wdt_i) && !por_i && !reset_event_i |=> ##1
    (ic0_reg[`INT_WAKE_BIT] || !$past(wake_int_i, 2)) &&
    (pir_reg[`WDT_WAKE_BIT] || !$past(wake_wdt_i, 2)))
    else $error("wake cause flag missing");
  pa_bit6_on_a: assert property (
    ra6_en && wr_en && paddr_i == `OFF_PA_LATCH |=>
    pal_reg[`PA_BIT6] == $past(pwdata_i[`PA_BIT6]))
    else $error("port A bit 6 not writable when enabled");
  pa_bit6_off_a: assert property (
    !ra6_en |=>
    !port_a_output_latch_o[`PA_BIT6] && !port_a_direction_o[`PA_BIT6])
    else $error("port A bit 6 active while disabled");
  pa_variant_a: assert property (
    !has_pa_bit6_i && psel_i && !penable_i && paddr_i == `OFF_PA_PINS |=>
    !prdata_o[`PA_BIT6])
    else $error("absent port A bit 6 reads one");
  unimpl_zero_a: assert property (
    psel_i && !penable_i && !pwrite_i && paddr_i == `OFF_STACK_PTR |=>
    prdata_o[5] == 1'b0 && prdata_o[31:8] == 24'h000000)
    else $error("unimplemented bit reads one");
  reset_clear_a: assert property (
    w.act == core_regs_pkg::ACT_RESET |=>
    pc_o == 21'h000000 && latu_reg == 8'h00 && lath_reg == 8'h00 &&
    tblu_reg == 8'h00 && table_read_latch_reg == 8'h00)
    else $error("reset did not clear PC or table state");
  resume_step_a: assert property (
    w.act == core_regs_pkg::ACT_RESUME |=>
    pc_o == $past(pc_reg) + `PC_STEP && $stable(tblh_reg))
    else $error("resume PC not advanced by two");
endmodule : core_register_reset_init

// *** design/core_regs_map.svh ***
// Offsets, masks, reset values and vectors of the core register set
`ifndef CORE_REGS_MAP_SVH
`define CORE_REGS_MAP_SVH
`define OFF_TOS_UPPER    8'h00
`define OFF_TOS_HIGH     8'h04
`define OFF_TOS_LOW      8'h08
`define OFF_STACK_PTR    8'h0C
`define OFF_PC_LOW       8'h10
`define OFF_PC_UP_LATCH  8'h14
`define OFF_PC_HI_LATCH  8'h18
`define OFF_TBL_UPPER    8'h1C
`define OFF_TBL_HIGH     8'h20
`define OFF_TBL_LOW      8'h24
`define OFF_TBL_LATCH    8'h28
`define OFF_PROD_HIGH    8'h2C
`define OFF_PROD_LOW     8'h30
`define OFF_INTCTL0      8'h34
`define OFF_INTCTL2      8'h38
`define OFF_INTCTL3      8'h3C
`define OFF_PA_LATCH     8'h40
`define OFF_PA_DIR       8'h44
`define OFF_PA_PINS      8'h48
`define OFF_FSR0_HIGH    8'h4C
`define OFF_FSR0_LOW     8'h50
`define OFF_PERIPH_FLAGS 8'h54
`define MASK_TOS_UPPER   8'h1F
`define MASK_STACK_PTR   8'hDF
`define MASK_PC_UPPER    8'h1F
`define MASK_TBL_UPPER   8'h3F
`define MASK_INTCTL2     8'hF5
`define MASK_INTCTL3     8'hDB
`define MASK_FSR_HIGH    8'h0F
`define RST_INTCTL2      8'hF5
`define RST_INTCTL3      8'hC0
`define RST_PA_DIR       8'h7F
`define VEC_HIGH         21'h000008
`define VEC_LOW          21'h000018
`define PC_STEP          21'h000002
`define STK_FULL_BIT     7
`define STK_UNF_BIT      6
`define GIE_HIGH_BIT     7
`define GIE_LOW_BIT      6
`define INT_WAKE_BIT     1
`define WDT_WAKE_BIT     0
`define PA_BIT6          6
`define OSC_EXT_CLK_IO   3'h5
`define OSC_RC_IO        3'h7
`endif

// *** design/core_regs_pkg.sv ***
// Types shared by the core register set
package core_regs_pkg;
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_RESET,
    ACT_VECTOR,
    ACT_RESUME
  } wake_act_t;
endpackage : core_regs_pkg

// *** design/wake_if.sv ***
// Action carrier between wake control and the register set
`timescale 1ns/10ps
interface wake_if;
  core_regs_pkg::wake_act_t act;
  logic [20:0]              vec;
  logic                     por;
  logic                     int_wake;
  logic                     wdt_wake;
  modport ctrl (output act, vec, por, int_wake, wdt_wake);
  modport core (input act, vec, por, int_wake, wdt_wake);
endinterface : wake_if

// *** design/core_wake_ctrl.sv ***
// Turns reset and wake events into one registered action
`timescale 1ns/10ps
`include "core_regs_map.svh"
module core_wake_ctrl (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Events
  input  wire logic por_i,
  input  wire logic reset_event_i,
  input  wire logic wake_int_i,
  input  wire logic wake_int_high_i,
  input  wire logic wake_wdt_i,
  input  wire logic gie_any_i,
  // Action
  wake_if.ctrl      w
);
  core_regs_pkg::wake_act_t act_next;
  logic [20:0]              vec_next;

  always_comb begin
    act_next = core_regs_pkg::ACT_NONE;
    vec_next = `VEC_LOW;
    if (wake_int_high_i) begin
      vec_next = `VEC_HIGH;
    end
    if (por_i || reset_event_i) begin
      act_next = core_regs_pkg::ACT_RESET;
    end else if (wake_int_i && gie_any_i) begin
      act_next = core_regs_pkg::ACT_VECTOR;
    end else if (wake_int_i || wake_wdt_i) begin
      act_next = core_regs_pkg::ACT_RESUME;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      w.act      <= core_regs_pkg::ACT_NONE;
      w.vec      <= `VEC_LOW;
      w.por      <= 1'b0;
      w.int_wake <= 1'b0;
      w.wdt_wake <= 1'b0;
    end else begin
      w.act      <= act_next;
      w.vec      <= vec_next;
      w.por      <= por_i;
      w.int_wake <= wake_int_i && !(por_i || reset_event_i);
      w.wdt_wake <= wake_wdt_i && !(por_i || reset_event_i);
    end
  end

  vec_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_int_i |=>
    w.vec == ($past(wake_int_high_i) ? `VEC_HIGH : `VEC_LOW))
    else $error("vector does not follow the wake priority");
endmodule : core_wake_ctrl

// *** tb/tb_top.sv ***
// Self-checking bench for the core register set
`timescale 1ns/10ps
`include "core_regs_map.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
  end end
module tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [3:0]  ev;
  logic        wake_int_high_i;
  logic [2:0]  osc_mode_i;
  logic        has_pa_bit6_i;
  logic [7:0]  port_a_pins_i;
  logic [7:0]  port_a_output_latch_o;
  logic [7:0]  port_a_direction_o;
  logic [20:0] pc_o;
  int          n_fail;
  int          compares;

  core_register_reset_init core_register_reset_init_i (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .psel_i                (psel_i),
    .penable_i             (penable_i),
    .pwrite_i              (pwrite_i),
    .paddr_i               (paddr_i),
    .pwdata_i              (pwdata_i),
    .prdata_o              (prdata_o),
    .pready_o              (pready_o),
    .pslverr_o             (pslverr_o),
    .por_i                 (ev[3]),
    .reset_event_i         (ev[2]),
    .wake_int_i            (ev[0]),
    .wake_int_high_i       (wake_int_high_i),
    .wake_wdt_i            (ev[1]),
    .osc_mode_i            (osc_mode_i),
    .has_pa_bit6_i         (has_pa_bit6_i),
    .port_a_pins_i         (port_a_pins_i),
    .port_a_output_latch_o (port_a_output_latch_o),
    .port_a_direction_o    (port_a_direction_o),
    .pc_o                  (pc_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // APB transfer, waits for pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    q   = prdata_o;
    err = pslverr_o;
    if (n >= 20) begin
      n_fail++;
      $display("CHECK FAILED at %0t: no pready", $time);
      wrap_up();
    end
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    #1;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {24'h000000, d}, q, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] x,
                     input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h00000000, q, e);
    `CHK(q, {24'h000000, x})
    `CHK(e, xe)
  endtask : rdc

  // Event pulse, then wait for the registers to update
  task automatic pulse(input logic [3:0] code, input logic hi);
    @(posedge clk_i);
    ev              <= code;
    wake_int_high_i <= hi;
    @(posedge clk_i);
    ev <= 4'h0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : pulse

  task automatic t_reset_values();
    `CHK(pc_o, 21'h000000)
    `CHK(port_a_direction_o, 8'h3F)
    rdc(`OFF_PC_LOW, 8'h00, 1'b0);
    rdc(`OFF_TBL_LATCH, 8'h00, 1'b0);
    rdc(`OFF_INTCTL2, `RST_INTCTL2, 1'b0);
    rdc(`OFF_INTCTL3, `RST_INTCTL3, 1'b0);
    rdc(`OFF_STACK_PTR, 8'h00, 1'b0);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_unimpl_bits();
    wr(`OFF_TOS_UPPER, 8'hFF);
    rdc(`OFF_TOS_UPPER, `MASK_TOS_UPPER, 1'b0);
    wr(`OFF_TBL_UPPER, 8'hFF);
    rdc(`OFF_TBL_UPPER, `MASK_TBL_UPPER, 1'b0);
    wr(`OFF_FSR0_HIGH, 8'hFF);
    rdc(`OFF_FSR0_HIGH, `MASK_FSR_HIGH, 1'b0);
    wr(`OFF_PC_UP_LATCH, 8'hFF);
    rdc(`OFF_PC_UP_LATCH, `MASK_PC_UPPER, 1'b0);
    wr(`OFF_INTCTL2, 8'hFF);
    rdc(`OFF_INTCTL2, `MASK_INTCTL2, 1'b0);
    wr(8'h58, 8'hFF);
    rdc(8'h58, 8'h00, 1'b1);
    rdc(8'h02, 8'h00, 1'b1);
    $display("test unimpl_bits done");
  endtask : t_unimpl_bits

  task automatic t_port_a_bit6();
    logic [7:0] x;
    @(posedge clk_i);
    port_a_pins_i <= 8'hFF;
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_i);
      osc_mode_i <= m[2:0];
      x = (m == 5 || m == 7) ? 8'hFF : 8'hBF;
      wr(`OFF_PA_LATCH, 8'hFF);
      wr(`OFF_PA_DIR, 8'hFF);
      rdc(`OFF_PA_LATCH, x, 1'b0);
      rdc(`OFF_PA_PINS, x, 1'b0);
      `CHK(port_a_output_latch_o, x)
      `CHK(port_a_direction_o, x)
    end
    @(posedge clk_i);
    has_pa_bit6_i <= 1'b0;
    osc_mode_i    <= `OSC_EXT_CLK_IO;
    wr(`OFF_PA_LATCH, 8'hFF);
    rdc(`OFF_PA_LATCH, 8'hBF, 1'b0);
    rdc(`OFF_PA_DIR, 8'hBF, 1'b0);
    rdc(`OFF_PA_PINS, 8'hBF, 1'b0);
    $display("test port_a_bit6 done");
  endtask : t_port_a_bit6

  task automatic t_vector_wake();
    wr(`OFF_PC_UP_LATCH, 8'h01);
    wr(`OFF_PC_HI_LATCH, 8'h23);
    wr(`OFF_PC_LOW, 8'h45);
    `CHK(pc_o, 21'h012345)
    wr(`OFF_INTCTL0, 8'h80);
    pulse(4'h1, 1'b1);
    `CHK(pc_o, `VEC_HIGH)
    rdc(`OFF_TOS_UPPER, 8'h01, 1'b0);
    rdc(`OFF_TOS_HIGH, 8'h23, 1'b0);
    rdc(`OFF_TOS_LOW, 8'h45, 1'b0);
    rdc(`OFF_STACK_PTR, 8'h01, 1'b0);
    rdc(`OFF_INTCTL0, 8'h82, 1'b0);
    wr(`OFF_INTCTL0, 8'h40);
    pulse(4'h1, 1'b0);
    `CHK(pc_o, `VEC_LOW)
    rdc(`OFF_TOS_LOW, 8'h08, 1'b0);
    rdc(`OFF_STACK_PTR, 8'h02, 1'b0);
    rdc(`OFF_INTCTL0, 8'h42, 1'b0);
    $display("test vector_wake done");
  endtask : t_vector_wake

  task automatic t_resume_wake();
    wr(`OFF_INTCTL0, 8'h00);
    pulse(4'h1, 1'b1);
    `CHK(pc_o, `VEC_LOW + `PC_STEP)
    rdc(`OFF_STACK_PTR, 8'h02, 1'b0);
    rdc(`OFF_TOS_LOW, 8'h08, 1'b0);
    rdc(`OFF_INTCTL0, 8'h02, 1'b0);
    pulse(4'h2, 1'b0);
    `CHK(pc_o, `VEC_LOW + 2 * `PC_STEP)
    rdc(`OFF_PERIPH_FLAGS, 8'h01, 1'b0);
    $display("test resume_wake done");
  endtask : t_resume_wake

  task automatic t_reset_event();
    wr(`OFF_TBL_LATCH, 8'h5A);
    wr(`OFF_TBL_UPPER, 8'h3F);
    wr(`OFF_PROD_LOW, 8'h77);
    pulse(4'h4, 1'b0);
    `CHK(pc_o, 21'h000000)
    rdc(`OFF_PC_UP_LATCH, 8'h00, 1'b0);
    rdc(`OFF_PC_HI_LATCH, 8'h00, 1'b0);
    rdc(`OFF_TBL_UPPER, 8'h00, 1'b0);
    rdc(`OFF_TBL_LATCH, 8'h00, 1'b0);
    rdc(`OFF_PROD_LOW, 8'h77, 1'b0);
    wr(`OFF_PC_LOW, 8'h10);
    pulse(4'h8, 1'b0);
    `CHK(pc_o, 21'h000000)
    rdc(`OFF_STACK_PTR, 8'h00, 1'b0);
    $display("test reset_event done");
  endtask : t_reset_event

  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #50000;
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    n_fail          = 0;
    compares        = 0;
    rst_i           = 1'b1;
    psel_i          = 1'b0;
    penable_i       = 1'b0;
    pwrite_i        = 1'b0;
    paddr_i         = 8'h00;
    pwdata_i        = 32'h00000000;
    ev              = 4'h0;
    wake_int_high_i = 1'b0;
    osc_mode_i      = 3'h0;
    has_pa_bit6_i   = 1'b1;
    port_a_pins_i   = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset_values();
    t_unimpl_bits();
    t_port_a_bit6();
    t_vector_wake();
    t_resume_wake();
    t_reset_event();
    wrap_up();
  end
endmodule : tb_top
